// File: include/eeprom_link_if.sv
// Two-wire link between the bus master and the EEPROM.
// Data line is open drain with a pull-up; the master alone makes the clock.
`timescale 1ns/10ps
interface eeprom_link_if;
  logic scl;
  logic host_sda_oe;
  logic dev_sda_oe;
  logic sda;
  assign sda = ~(host_sda_oe | dev_sda_oe);
  modport host (output scl, output host_sda_oe, input sda);
  modport dev (input scl, input sda, output dev_sda_oe);
endinterface

// File: include/eeprom_pkg.sv
// Shared constants of the serial EEPROM read path and its bus master.
// Assumes a two-wire link with one open-drain data line and a master-made clock.
package eeprom_pkg;
  // Device type identifiers in the upper nibble of the address byte
  localparam logic [3:0] TYPE_MAIN = 4'hA;
  localparam logic [3:0] TYPE_SPECIAL = 4'hB;
  // Special area selected by word address bits 7:6
  localparam logic [1:0] AREA_PAGE = 2'h0;
  localparam logic [1:0] AREA_SERIAL = 2'h1;
  localparam logic [1:0] AREA_LOCK = 2'h2;
  localparam logic [1:0] AREA_PROTECT = 2'h3;
  // Field positions
  localparam int TYPE_HI = 7;
  localparam int TYPE_LO = 4;
  localparam int SEL_HI = 3;
  localparam int SEL_LO = 1;
  localparam int RW_POS = 0;
  localparam int AREA_HI = 7;
  localparam int AREA_LO = 6;
  localparam int OFS_W = 4;
  localparam int SPECIAL_POS = 4;
  // Sizes
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 8;
  localparam int MAIN_BYTES = 256;
  localparam int PAGE_BYTES = 16;
  localparam int SERIAL_W = 128;
  localparam int LAST_BIT = 7;
  localparam logic [BYTE_W-1:0] FILL_BYTE = 8'h00;
  // Link timing: one quarter of a link bit
  localparam int REF_CLK_MHZ = 20;
  localparam int T_QTR_NS = 250;
  localparam int QTR_CYC = (T_QTR_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int QTR_MIN = 2;
  typedef enum logic [3:0] {
    OP_CUR_READ = 4'h1,
    OP_RAND_READ = 4'h2,
    OP_WRITE = 4'h4,
    OP_PROBE = 4'h8
  } op_e;
endpackage

// File: testbench/eeprom_link_monitor.sv
// Checker for the two-wire link between the bus master and the EEPROM.
// Assumes it sits beside the link interface and samples on the reference clock.
`timescale 1ns/10ps
module eeprom_link_monitor #(
  parameter int QTR = 2
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic scl,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);
  logic [7:0] hi_cnt;
  logic [7:0] lo_cnt;
  // Saturating run lengths of the link clock levels
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      hi_cnt <= 8'h00;
      lo_cnt <= 8'h00;
    end
    else
    begin
      hi_cnt <= scl ? hi_cnt + {7'h00, hi_cnt != 8'hFF} : 8'h00;
      lo_cnt <= scl ? 8'h00 : lo_cnt + {7'h00, lo_cnt != 8'hFF};
    end
  end
  sequence dev_grab_s;
    $rose(dev_sda_oe);
  endsequence
  sequence bit_end_s;
    ##[1:40] $fell(scl);
  endsequence
  dev_edge_a: assert property ($changed(dev_sda_oe) |-> $fell(scl))
    else $error("device data enable moved away from a link clock fall");
  dev_hold_a: assert property (dev_grab_s |=> dev_sda_oe until $fell(scl))
    else $error("device released the data line inside a bit");
  dev_bound_a: assert property (dev_grab_s |-> bit_end_s)
    else $error("device drove the data line without a clock fall");
  host_start_a: assert property (scl && $past(scl) && $fell(sda) |-> host_sda_oe && !dev_sda_oe)
    else $error("start condition not made by the master alone");
  scl_low_a: assert property ($rose(scl) |-> lo_cnt >= 8'(2 * QTR))
    else $error("link clock low phase too short");
  scl_high_a: assert property ($fell(scl) |-> hi_cnt >= 8'(2 * QTR))
    else $error("link clock high phase too short");
  idle_release_a: assert property (hi_cnt > 8'(3 * QTR) |-> !dev_sda_oe)
    else $error("device drives the data line while the link is idle");
  sda_resolve_a: assert property (sda == !(host_sda_oe || dev_sda_oe))
    else $error("data line level differs from the open-drain drivers");
endmodule

// File: testbench/serial_eeprom_read_ops_tb_top.sv
// Bench for the EEPROM read path: master and device joined by the link.
// Assumes a 20 MHz reference clock; the master divides the link clock from it.
`timescale 1ns/10ps
module serial_eeprom_read_ops_tb_top;
  import eeprom_pkg::*;
  // Arbitrary serial value
  localparam logic [127:0] SN = 128'h1F2E_3D4C_5B6A_7988_0A1B_2C3D_4E5F_6071;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  op_e cmd_op_i = OP_CUR_READ;
  logic cmd_special_i = 1'b0;
  logic [2:0] cmd_select_i = 3'h0;
  logic [7:0] cmd_word_i = 8'h00;
  logic [4:0] cmd_len_i = 5'h01;
  logic [7:0] wr_data_i = 8'h00;
  logic [2:0] pins = 3'h0;
  logic wp = 1'b0;
  logic soft_protect_bit = 1'b0;
  logic lock = 1'b0;
  logic cmd_ready_o, wr_take_o, rd_valid_o, done_o, nack_o;
  logic [7:0] rd_data_o, addr_counter_o;
  logic [7:0] mem [256];
  logic [7:0] page [16];
  logic [7:0] rdq [$];
  logic [7:0] wq [$];
  logic nq [$];
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  eeprom_link_if link ();
  eeprom_host #(.QTR(2)) eeprom_host_inst (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .link(link), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
    .cmd_op_i(cmd_op_i), .cmd_special_i(cmd_special_i), .cmd_select_i(cmd_select_i),
    .cmd_word_i(cmd_word_i), .cmd_len_i(cmd_len_i), .wr_data_i(wr_data_i),
    .wr_take_o(wr_take_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .done_o(done_o), .nack_o(nack_o));
  eeprom_dev #(.SERIAL_NUMBER(SN)) eeprom_dev_inst (.link(link), .nrst_i(nrst_i),
    .chip_select_bit2_i(pins[2]), .chip_select_bit1_i(pins[1]),
    .chip_select_bit0_i(pins[0]), .write_protect_pin_i(wp), .soft_protect_bit_i(soft_protect_bit),
    .page_locked_i(lock), .addr_counter_o(addr_counter_o));
  eeprom_link_monitor #(.QTR(2)) eeprom_link_monitor_inst (.ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i), .scl(link.scl), .host_sda_oe(link.host_sda_oe),
    .dev_sda_oe(link.dev_sda_oe), .sda(link.sda));
  initial
  begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Result watcher, write data feeder and hang guard
  always @(negedge ref_clk_i)
  begin
    if (rd_valid_o === 1'b1 && rdq.size() == 0)
      check("unexpected byte", 8'hxx, rd_data_o);
    else if (rd_valid_o === 1'b1)
      check("read byte", rdq.pop_front(), rd_data_o);
    if (done_o === 1'b1 && nq.size() != 0)
      check("nack", {7'h00, nq.pop_front()}, {7'h00, nack_o});
    if (wr_take_o === 1'b1 && wq.size() != 0)
      wr_data_i = wq.pop_front();
    cycles++;
    if (cycles > 40000)
    begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic run(op_e op, logic sp, logic [7:0] word, int len, logic [2:0] sel, logic nk);
    int t;
    t = 0;
    @(negedge ref_clk_i);
    while (cmd_ready_o !== 1'b1 && t < 100)
    begin
      @(negedge ref_clk_i);
      t++;
    end
    cmd_op_i = op;
    cmd_special_i = sp;
    cmd_word_i = word;
    cmd_len_i = 5'(len);
    cmd_select_i = sel;
    cmd_valid_i = 1'b1;
    nq.push_back(nk);
    @(negedge ref_clk_i);
    cmd_valid_i = 1'b0;
    t = 0;
    while (done_o !== 1'b1 && t < 4000)
    begin
      @(negedge ref_clk_i);
      t++;
    end
    if (t >= 4000)
      check("done", 8'h01, {7'h00, done_o});
  endtask
  task automatic wr(logic sp, logic [7:0] word, int len, logic nk);
    logic [7:0] b;
    for (int i = 0; i < len; i++)
    begin
      b = 8'($urandom);
      wq.push_back(b);
      if (!nk && !sp)
        mem[{word[7:4], 4'(word[3:0] + i)}] = b;
      if (!nk && sp)
        page[4'(word[3:0] + i)] = b;
    end
    wr_data_i = wq.pop_front();
    run(OP_WRITE, sp, word, len, pins, nk);
  endtask
  task automatic rd(logic sp, logic [7:0] word, int len);
    int k;
    for (int i = 0; i < len; i++)
    begin
      k = (int'(word[3:0]) + i) % 16;
      if (!sp)
        rdq.push_back(mem[8'(word + i)]);
      else if (word[7:6] == AREA_PAGE)
        rdq.push_back(page[k]);
      else if (word[7:6] == AREA_SERIAL)
        rdq.push_back(SN[8 * (15 - k) +: 8]);
      else
        rdq.push_back({7'h00, soft_protect_bit});
    end
    run(OP_RAND_READ, sp, word, len, pins, 1'b0);
  endtask
  initial
  begin
    void'($urandom(79));
    pins = 3'($urandom);
    repeat (4) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    nrst_i = 1'b1;
    wr(1'b0, 8'hF0, 16, 1'b0);
    wr(1'b0, 8'h00, 16, 1'b0);
    rd(1'b0, 8'hFE, 4);
    check("counter", 8'h02, addr_counter_o);
    rdq.push_back(mem[8'h02]);
    run(OP_CUR_READ, 1'b0, 8'h00, 1, pins, 1'b0);
    $display("main array wrap and current read done");
    wr(1'b1, 8'h05, 16, 1'b0);
    rd(1'b1, 8'h3A, 4);
    rdq.push_back(mem[8'h0E]);
    run(OP_CUR_READ, 1'b0, 8'h00, 1, pins, 1'b0);
    check("counter", 8'h0F, addr_counter_o);
    $display("page read done");
    rd(1'b1, 8'h40, 18);
    wr(1'b1, 8'h40, 1, 1'b1);
    rd(1'b1, 8'h70, 2);
    $display("serial read done");
    for (int s = 0; s < 2; s++)
    begin
      soft_protect_bit = s[0];
      wp = s[0];
      rd(1'b1, 8'hC7, 3);
      rd(1'b0, 8'hF3, 2);
    end
    wp = 1'b0;
    soft_protect_bit = 1'b0;
    $display("protect bit read done");
    for (int l = 0; l < 2; l++)
    begin
      lock = l[0];
      wr_data_i = 8'($urandom);
      run(OP_PROBE, 1'b1, 8'h00, 1, pins, l[0]);
      rd(1'b1, 8'h00, 1);
    end
    $display("lock probe done");
    run(OP_RAND_READ, 1'b0, 8'h10, 1, ~pins, 1'b1);
    $display("select mismatch done");
    repeat (20) @(negedge ref_clk_i);
    check("bytes left", 8'h00, 8'(rdq.size()));
    complete_run();
  end
endmodule

// File: verilog/eeprom_dev.sv
// EEPROM end of the link: address decode, reads of all areas, buffered writes.
// Assumes the link clock stops high between frames and SDA changes only while it is low.
// Summary of operation
// - Read without word address sends current byte
// - Counter keeps last location, advances per byte
// - Main array read wraps top to bottom
// - Master ends reads with nack then stop
// - One counter shared; page access loads it
// - Master prefers random read over current read
// - Random read: dummy write, restart, read
// - Continue on ack, release line on nack
// - Page read: type 1011, bits 7:6 zero
// - Page read wraps within the page
// - Page data acked unlocked and not write protected, else nacked
// - Start discards pending write; stop idles
// - Protect read returns seven zeros and bit
// - Further protect reads repeat same byte
// - Serial read: type 1011, bits 7:6 01
// - Unique serial needs full read from zero
// - Serial area never written
// - Serial read wraps within its sixteen bytes
// - Address byte: type, select bits, read bit
// - Reads ignore both write protections
`timescale 1ns/10ps
module eeprom_dev #(
  // Arbitrary factory serial value
  parameter logic [eeprom_pkg::SERIAL_W-1:0] SERIAL_NUMBER =
    128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210
) (
  eeprom_link_if.dev link,
  input wire logic nrst_i,
  input wire logic chip_select_bit2_i,
  input wire logic chip_select_bit1_i,
  input wire logic chip_select_bit0_i,
  input wire logic write_protect_pin_i,
  input wire logic soft_protect_bit_i,
  input wire logic page_locked_i,
  output logic [eeprom_pkg::ADDR_W-1:0] addr_counter_o
);
  import eeprom_pkg::*;

  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_DEV = 9'h002,
    S_DEV_ACK = 9'h004,
    S_WORD = 9'h008,
    S_WORD_ACK = 9'h010,
    S_WDATA = 9'h020,
    S_WDATA_ACK = 9'h040,
    S_TX = 9'h080,
    S_MACK = 9'h100
  } dev_state_e;

  typedef struct packed {
    dev_state_e st;
    logic [2:0] bitc;
    logic [BYTE_W-1:0] shreg;
    logic oe;
    logic rw;
    logic special;
    logic [1:0] area;
    logic [ADDR_W-1:0] addr;
    logic [PAGE_BYTES-1:0] pvalid;
    logic [ADDR_W-OFS_W-1:0] phi;
    logic ppage;
    logic [5:0] sync1;
    logic [5:0] sync2;
  } dev_s;

  localparam dev_s RESET_VAL = '{st: S_IDLE, default: '0};

  dev_s r;
  dev_s n;
  logic sda_rise;
  logic start;
  logic stop;
  logic [BYTE_W-1:0] b;
  logic [BYTE_W-1:0] tx_byte;
  logic [2:0] cs;
  logic write_ok;
  logic accept;
  logic pend_we;

  logic [BYTE_W-1:0] main_mem [MAIN_BYTES];
  logic [BYTE_W-1:0] page_mem [PAGE_BYTES];
  logic [BYTE_W-1:0] pend_mem [PAGE_BYTES];

  // Byte seen at the counter for the selected area
  function automatic logic [BYTE_W-1:0] read_byte(input logic special, input logic [1:0] area,
                                                  input logic [ADDR_W-1:0] a, input logic soft_protect_bit);
    logic [OFS_W-1:0] ofs;
    ofs = a[OFS_W-1:0];
    if (!special)
      read_byte = main_mem[a];
    else
      case (area)
        AREA_PAGE: read_byte = page_mem[ofs];
        AREA_SERIAL: read_byte = SERIAL_NUMBER[SERIAL_W-1-BYTE_W*ofs -: BYTE_W];
        AREA_PROTECT: read_byte = {FILL_BYTE[BYTE_W-1:1], soft_protect_bit};
        default: read_byte = FILL_BYTE;
      endcase
  endfunction

  // Counter advance after a transmitted byte
  function automatic logic [ADDR_W-1:0] next_addr(input logic special, input logic [1:0] area,
                                                  input logic [ADDR_W-1:0] a);
    if (!special)
      next_addr = a + 1'b1;
    else if (area == AREA_PROTECT)
      next_addr = a;
    else
      next_addr = {{(ADDR_W-OFS_W){1'b0}}, a[OFS_W-1:0] + 1'b1};
  endfunction

  // Data sampled while the clock is high, compared at the falling edge
  always_ff @(posedge link.scl or negedge nrst_i)
  begin
    if (!nrst_i)
      sda_rise <= 1'b1;
    else
      sda_rise <= link.sda;
  end

  assign start = sda_rise & ~link.sda;
  assign stop = ~sda_rise & link.sda;
  assign b = {r.shreg[BYTE_W-2:0], sda_rise};
  assign cs = r.sync2[5:3];
  assign write_ok = ~r.sync2[2] & ~r.sync2[1];

  always_comb
  begin
    tx_byte = read_byte(r.special, r.area, r.addr, r.sync2[1]);
    n = r;
    n.sync1 = {chip_select_bit2_i, chip_select_bit1_i, chip_select_bit0_i,
               write_protect_pin_i, soft_protect_bit_i, page_locked_i};
    n.sync2 = r.sync1;
    accept = 1'b0;
    pend_we = 1'b0;
    if (!r.special)
      accept = write_ok;
    else
      case (r.area)
        AREA_PAGE: accept = write_ok & ~r.sync2[0];
        AREA_SERIAL: accept = 1'b0;
        AREA_LOCK: accept = ~r.sync2[0];
        default: accept = 1'b1;
      endcase
    if (start)
    begin
      n.st = S_DEV;
      n.bitc = '0;
      n.oe = 1'b0;
      n.pvalid = '0;
    end
    else if (stop)
    begin
      n.st = S_IDLE;
      n.oe = 1'b0;
      n.pvalid = '0;
    end
    else
      case (r.st)
        S_IDLE:
          n.oe = 1'b0;
        S_DEV, S_WORD, S_WDATA:
        begin
          n.shreg = b;
          n.bitc = r.bitc + 1'b1;
          n.oe = 1'b0;
          if (r.bitc == 3'(LAST_BIT))
          begin
            if (r.st == S_DEV)
            begin
              if ((b[TYPE_HI:TYPE_LO] == TYPE_MAIN || b[TYPE_HI:TYPE_LO] == TYPE_SPECIAL)
                  && b[SEL_HI:SEL_LO] == cs)
              begin
                n.st = S_DEV_ACK;
                n.oe = 1'b1;
                n.rw = b[RW_POS];
                n.special = b[SPECIAL_POS];
              end
              else
                n.st = S_IDLE;
            end
            else if (r.st == S_WORD)
            begin
              n.st = S_WORD_ACK;
              n.oe = 1'b1;
              n.pvalid = '0;
              if (!r.special)
              begin
                n.addr = b;
                n.phi = b[ADDR_W-1:OFS_W];
              end
              else
              begin
                n.area = b[AREA_HI:AREA_LO];
                if (b[AREA_HI:AREA_LO] == AREA_PAGE || b[AREA_HI:AREA_LO] == AREA_SERIAL)
                  n.addr = {{(ADDR_W-OFS_W){1'b0}}, b[OFS_W-1:0]};
              end
              n.ppage = r.special;
            end
            else
            begin
              n.st = S_WDATA_ACK;
              n.oe = accept;
              if (accept && (!r.special || r.area == AREA_PAGE))
              begin
                pend_we = 1'b1;
                n.pvalid[r.addr[OFS_W-1:0]] = 1'b1;
                n.addr = {r.addr[ADDR_W-1:OFS_W], r.addr[OFS_W-1:0] + 1'b1};
              end
            end
          end
        end
        S_DEV_ACK:
        begin
          n.bitc = '0;
          if (r.rw)
          begin
            n.st = S_TX;
            n.shreg = tx_byte;
            n.oe = ~tx_byte[BYTE_W-1];
          end
          else
          begin
            n.st = S_WORD;
            n.oe = 1'b0;
          end
        end
        S_WORD_ACK, S_WDATA_ACK:
        begin
          n.st = S_WDATA;
          n.bitc = '0;
          n.oe = 1'b0;
        end
        S_TX:
        begin
          n.bitc = r.bitc + 1'b1;
          n.shreg = {r.shreg[BYTE_W-2:0], 1'b0};
          n.oe = ~r.shreg[BYTE_W-2];
          if (r.bitc == 3'(LAST_BIT))
          begin
            n.st = S_MACK;
            n.oe = 1'b0;
            n.addr = next_addr(r.special, r.area, r.addr);
          end
        end
        S_MACK:
        begin
          n.bitc = '0;
          if (!sda_rise)
          begin
            n.st = S_TX;
            n.shreg = tx_byte;
            n.oe = ~tx_byte[BYTE_W-1];
          end
          else
          begin
            n.st = S_IDLE;
            n.oe = 1'b0;
          end
        end
        default:
        begin
          n.st = S_IDLE;
          n.oe = 1'b0;
        end
      endcase
  end

  always_ff @(negedge link.scl or negedge nrst_i)
  begin
    if (!nrst_i)
      r <= RESET_VAL;
    else
      r <= n;
  end

  // Writes are held until a stop, so a start throws them away
  always_ff @(negedge link.scl)
  begin
    if (pend_we)
      pend_mem[r.addr[OFS_W-1:0]] <= b;
    if (stop && !start)
      for (int i = 0; i < PAGE_BYTES; i++)
        if (r.pvalid[i])
        begin
          if (r.ppage)
            page_mem[i] <= pend_mem[i];
          else
            main_mem[{r.phi, OFS_W'(i)}] <= pend_mem[i];
        end
  end

  assign link.dev_sda_oe = r.oe;
  assign addr_counter_o = r.addr;
endmodule

// File: verilog/eeprom_host.sv
// Bus master end: runs commands against the EEPROM over the two-wire link.
// Assumes one command at a time; the link clock is divided from ref_clk_i.
`timescale 1ns/10ps
module eeprom_host #(
  parameter int QTR = eeprom_pkg::QTR_CYC
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  eeprom_link_if.host link,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input eeprom_pkg::op_e cmd_op_i,
  input wire logic cmd_special_i,
  input wire logic [2:0] cmd_select_i,
  input wire logic [7:0] cmd_word_i,
  input wire logic [4:0] cmd_len_i,
  input wire logic [7:0] wr_data_i,
  output logic wr_take_o,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic done_o,
  output logic nack_o
);
  import eeprom_pkg::*;

  if (QTR < QTR_MIN || QTR > 255)
  begin : g_check
    $error("Quarter bit count out of range");
  end

  typedef enum logic [6:0] {
    H_IDLE = 7'h01,
    H_START = 7'h02,
    H_TX = 7'h04,
    H_TACK = 7'h08,
    H_RX = 7'h10,
    H_RACK = 7'h20,
    H_STOP = 7'h40
  } host_state_e;

  typedef enum logic [3:0] {
    P_ADDR_W = 4'h1,
    P_WORD = 4'h2,
    P_DATA = 4'h4,
    P_ADDR_R = 4'h8
  } host_step_e;

  typedef struct packed {
    host_state_e st;
    host_step_e step;
    logic [7:0] tick;
    logic [1:0] q;
    logic [2:0] bitc;
    logic [7:0] shreg;
    logic scl;
    logic oe;
    op_e op;
    logic special;
    logic [2:0] sel;
    logic [7:0] word;
    logic [4:0] len;
    logic fin;
    logic sda_s1;
    logic sda_s2;
    logic [7:0] rd_data;
    logic rd_valid;
    logic wr_take;
    logic done;
    logic nack;
  } host_s;

  localparam host_s RESET_VAL = '{st: H_IDLE, step: P_ADDR_W, op: OP_CUR_READ, scl: 1'b1,
                                  sda_s1: 1'b1, sda_s2: 1'b1, default: '0};

  host_s r;
  host_s n;

  always_comb
  begin
    n = r;
    n.sda_s1 = link.sda;
    n.sda_s2 = r.sda_s1;
    n.rd_valid = 1'b0;
    n.wr_take = 1'b0;
    n.done = 1'b0;
    if (r.st == H_IDLE)
    begin
      n.scl = 1'b1;
      n.oe = 1'b0;
      n.q = '0;
      n.tick = '0;
      if (cmd_valid_i)
      begin
        n.st = H_START;
        n.op = cmd_op_i;
        n.special = cmd_special_i;
        n.sel = cmd_select_i;
        n.word = cmd_word_i;
        n.len = cmd_len_i;
        n.fin = 1'b0;
        n.nack = 1'b0;
        n.q = 2'd3;
        n.step = (cmd_op_i == OP_CUR_READ) ? P_ADDR_R : P_ADDR_W;
      end
    end
    else if (r.tick != 8'(QTR - 1))
      n.tick = r.tick + 1'b1;
    else
    begin
      n.tick = '0;
      n.q = r.q + 1'b1;
      // Clock stands high after a stop
      n.scl = (r.q == 2'd1) || (r.q == 2'd2) || (r.q == 2'd3 && r.st == H_STOP);
      // Data moves one quarter after the clock falls
      if (r.q == 2'd0)
        case (r.st)
          H_START: n.oe = 1'b0;
          H_STOP: n.oe = 1'b1;
          H_TX: n.oe = ~r.shreg[7];
          H_RACK: n.oe = (r.len != 5'd1);
          default: n.oe = 1'b0;
        endcase
      else if (r.q == 2'd2)
      begin
        if (r.st == H_START)
          n.oe = 1'b1;
        if (r.st == H_STOP)
          n.oe = 1'b0;
      end
      else if (r.q == 2'd3)
        case (r.st)
          H_START:
          begin
            n.bitc = '0;
            // Idle preamble: one quarter with the clock high and the data line high
            if (!r.oe)
              n.st = H_START;
            else if (r.fin)
              n.st = H_STOP;
            else
            begin
              n.st = H_TX;
              n.shreg = {r.special ? TYPE_SPECIAL : TYPE_MAIN, r.sel,
                         r.step == P_ADDR_R};
            end
          end
          H_TX:
          begin
            n.bitc = r.bitc + 1'b1;
            n.shreg = {r.shreg[6:0], 1'b0};
            if (r.bitc == 3'(LAST_BIT))
              n.st = H_TACK;
          end
          H_TACK:
          begin
            n.bitc = '0;
            if (r.step == P_DATA && r.op == OP_PROBE)
            begin
              n.nack = r.sda_s2;
              n.fin = 1'b1;
              n.st = H_START;
            end
            else if (r.sda_s2)
            begin
              n.nack = 1'b1;
              n.st = H_STOP;
            end
            else
              case (r.step)
                P_ADDR_W:
                begin
                  n.st = H_TX;
                  n.shreg = r.word;
                  n.step = P_WORD;
                end
                P_WORD:
                  if (r.op == OP_RAND_READ)
                  begin
                    n.st = H_START;
                    n.step = P_ADDR_R;
                  end
                  else
                  begin
                    n.st = H_TX;
                    n.shreg = wr_data_i;
                    n.wr_take = 1'b1;
                    n.step = P_DATA;
                  end
                P_DATA:
                  if (r.len <= 5'd1)
                    n.st = H_STOP;
                  else
                  begin
                    n.len = r.len - 1'b1;
                    n.st = H_TX;
                    n.shreg = wr_data_i;
                    n.wr_take = 1'b1;
                  end
                default:
                  n.st = H_RX;
              endcase
          end
          H_RX:
          begin
            n.bitc = r.bitc + 1'b1;
            n.shreg = {r.shreg[6:0], r.sda_s2};
            if (r.bitc == 3'(LAST_BIT))
            begin
              n.st = H_RACK;
              n.rd_data = {r.shreg[6:0], r.sda_s2};
              n.rd_valid = 1'b1;
            end
          end
          H_RACK:
          begin
            n.bitc = '0;
            if (r.len <= 5'd1)
              n.st = H_STOP;
            else
            begin
              n.len = r.len - 1'b1;
              n.st = H_RX;
            end
          end
          H_STOP:
          begin
            n.st = H_IDLE;
            n.done = 1'b1;
          end
          default:
            n.st = H_IDLE;
        endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      r <= RESET_VAL;
    else
      r <= n;
  end

  assign cmd_ready_o = (r.st == H_IDLE);
  assign link.scl = r.scl;
  assign link.host_sda_oe = r.oe;
  assign wr_take_o = r.wr_take;
  assign rd_data_o = r.rd_data;
  assign rd_valid_o = r.rd_valid;
  assign done_o = r.done;
  assign nack_o = r.nack;
endmodule
